/* kfpf_params.svh */
// Constants of the key-fob and header packet framer
`ifndef KFPF_PARAMS_SVH
`define KFPF_PARAMS_SVH
`define KFPF_PRE_AA      8'hAA
`define KFPF_SYNC0       8'h2D
`define KFPF_SYNC1       8'hD4
`define KFPF_PHR_PRE     8'h55
`define KFPF_PHR_SYNC0   8'h90
`define KFPF_PHR_SYNC1   8'h4E
`define KFPF_PRE_BYTES   7'h04
`define KFPF_REQ_PAY     7'h40
`define KFPF_ACK_PAY     7'h03
`define KFPF_ACK_CH0     8'h41
`define KFPF_ACK_CH1     8'h43
`define KFPF_ACK_CH2     8'h4B
`define KFPF_CRC16_POLY  16'h8005
`define KFPF_CRC16_INIT  16'hFFFF
`define KFPF_CRC32_POLY  32'h04C11DB7
`define KFPF_CRC32_INIT  32'hFFFFFFFF
`define KFPF_TYPEA_LEN   11'h003
`define KFPF_TYPEB_LEN   11'h009
`define KFPF_TYPEB_STAT  11'h004
`define KFPF_BTN_BITS    5
`define KFPF_REQ_FRAME   11'h042
`define KFPF_ACK_FRAME   11'h005
`define KFPF_LEN_OPEN    11'h7FF
`define KFPF_HDR_BYTES   11'h002
`define KFPF_HDR_FCS_BIT 4
`define KFPF_HDR_DW_BIT  3
`endif

/* kfpf_pkg.sv */
// Types of the key-fob and header packet framer
package kfpf_pkg;
  typedef enum logic [1:0] {
    MODE_TYPEA  = 2'h0,
    MODE_TYPEB  = 2'h1,
    MODE_TWOWAY = 2'h2,
    MODE_PHR    = 2'h3
  } kfpf_mode_t;
  typedef enum logic [2:0] {
    ST_LISTEN = 3'h0,
    ST_RX     = 3'h1,
    ST_TXPRE  = 3'h2,
    ST_TXSYNC = 3'h3,
    ST_TXHDR  = 3'h4,
    ST_TXPAY  = 3'h5,
    ST_TXCRC  = 3'h6
  } kfpf_state_t;
  typedef enum logic [1:0] {
    FN_HOLD = 2'h0,
    FN_LOW  = 2'h1,
    FN_HIGH = 2'h2,
    FN_NONE = 2'h3
  } kfpf_fn_t;
endpackage

/* kfpf_framer.sv */
// Packet framer for key-fob, two-way and header-based frames
// Overview of operation
// - Type A: preamble, sync, byte, complement, byte
// - Byte holds four 2-bit codes, output three first
// - Codes 00 hold, 01 low, 10 high
// - Type B: preamble, sync, id, status, count, CRC
// - Low five status bits are button state
// - Type B CRC-16 0x8005 seed 0xFFFF checked
// - Node listens by default for frame or button
// - Button sends 64-byte request frame with CRC
// - Good request answered by ack, then LED
// - Ack payload is the three bytes ACK
// - Header: flag, reserved, FCS, whitening, length
// - Mode-switch flag always sent as zero
// - Header outside CRC; payload plus CRC second
// - Receive length taken from received header
// - CRC-16 and CRC-32 run in parallel, selected
// - Header frames use 0101 preamble, sync 0x904E
// - Header bytes returned to host bit-reversed
`timescale 1ns/1ps
`include "kfpf_params.svh"
`default_nettype none
module kfpf_framer
  import kfpf_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [1:0] MODE,
  input  wire logic       PHR_FCS16,
  input  wire logic       PHR_WHITEN,
  input  wire logic       BUTTON,
  input  wire logic       LINK_RX_START,
  input  wire logic       LINK_RX_VALID,
  input  wire logic [7:0] LINK_RX_DATA,
  output logic            LINK_TX_VALID,
  input  wire logic       LINK_TX_READY,
  output logic [7:0]      LINK_TX_DATA,
  output logic            LINK_TX_LAST,
  input  wire logic       HOST_TX_VALID,
  output logic            HOST_TX_READY,
  input  wire logic [7:0] HOST_TX_DATA,
  output logic            HOST_RX_VALID,
  output logic [7:0]      HOST_RX_DATA,
  output logic            HOST_RX_HEADER,
  output logic            HOST_RX_GOOD,
  output logic            HOST_RX_BAD,
  output logic            RX_WHITEN,
  output logic            LED_OUTPUT_THREE,
  output logic            LED_OUTPUT_TWO,
  output logic            LED_OUTPUT_ONE,
  output logic            LED_OUTPUT_ZERO,
  output logic [4:0]      BUTTON_STATE,
  output logic            ACTIVITY_LED
);

  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = d[7 - i];
    return r;
  endfunction

  function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                             input logic [7:0]  d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb)
        r = r ^ `KFPF_CRC16_POLY;
    end
    return r;
  endfunction

  function automatic logic [31:0] crc32_byte(input logic [31:0] c,
                                             input logic [7:0]  d);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      fb = r[31] ^ d[i];
      r = {r[30:0], 1'b0};
      if (fb)
        r = r ^ `KFPF_CRC32_POLY;
    end
    return r;
  endfunction

  kfpf_state_t state_ff;
  kfpf_mode_t  mode;
  logic [10:0] rx_cnt_ff;
  logic [10:0] rx_len_ff;
  logic [6:0]  tx_cnt_ff;
  logic        tx_ack_ff;
  logic        await_ff;
  logic        fcs16_ff;
  logic        ack_ok_ff;
  logic [7:0]  rx_b0_ff;
  logic [7:0]  rx_b1_ff;
  logic [15:0] crc16_ff;
  logic [31:0] crc32_ff;
  logic [15:0] nxt_crc16;
  logic [31:0] nxt_crc32;
  logic [2:0]  btn_sync_ff;
  logic        btn_lvl_ff;
  logic [3:0]  led_ff;
  logic        tx_full_ff;
  logic [7:0]  crc_din;
  logic        is_phr;
  logic        btn_press;
  logic [10:0] hdr_off;
  logic [10:0] crc_n;
  logic [10:0] pay_idx;
  logic        rx_take;
  logic        rx_last;
  logic        rx_pay;
  logic        rx_good;
  logic [7:0]  ack_ch;
  logic [10:0] rx_hlen;
  logic        gen_valid;
  logic [7:0]  gen_byte;
  logic        seg_end;
  logic        take;
  logic [6:0]  pay_n;
  logic [10:0] tx_len;
  logic [15:0] tx_hdr;
  logic [7:0]  rx_rev;
  logic [7:0]  b0_rev;

  assign mode    = kfpf_mode_t'(MODE);
  assign is_phr  = mode == MODE_PHR;
  assign hdr_off = is_phr ? `KFPF_HDR_BYTES : 11'h000;
  assign crc_n   = fcs16_ff ? 11'h002 : 11'h004;
  assign pay_idx = rx_cnt_ff - hdr_off;
  assign rx_take = state_ff == ST_RX && LINK_RX_VALID;
  assign rx_last = rx_cnt_ff == rx_len_ff - 11'h001;
  assign rx_pay  = rx_cnt_ff >= hdr_off &&
                   rx_cnt_ff < rx_len_ff - crc_n;
  // Length field sits in the low 11 bits of the host-order header
  assign rx_rev  = rev8(LINK_RX_DATA);
  assign b0_rev  = rev8(rx_b0_ff);
  assign rx_hlen = {b0_rev[2:0], rx_rev};
  assign pay_n   = tx_ack_ff ? `KFPF_ACK_PAY : `KFPF_REQ_PAY;
  assign tx_len  = {4'h0, pay_n} + crc_n;
  // Mode-switch and reserved bits are forced to zero
  assign tx_hdr  = {3'h0, fcs16_ff, PHR_WHITEN, tx_len};
  assign btn_press = btn_sync_ff[2] == btn_sync_ff[1] &&
                     btn_sync_ff[2] && !btn_lvl_ff;

  always_comb
  begin
    unique case (pay_idx[1:0])
      2'h0:    ack_ch = `KFPF_ACK_CH0;
      2'h1:    ack_ch = `KFPF_ACK_CH1;
      default: ack_ch = `KFPF_ACK_CH2;
    endcase
  end

  always_comb
  begin
    unique case (mode)
      MODE_TYPEA: rx_good = rx_b1_ff == ~rx_b0_ff &&
                            LINK_RX_DATA == rx_b0_ff;
      MODE_PHR:   rx_good = fcs16_ff ? nxt_crc16 == 16'h0000
                                     : nxt_crc32 == 32'h00000000;
      default:    rx_good = nxt_crc16 == 16'h0000;
    endcase
  end

  // Frame generator; one output register keeps data registered
  always_comb
  begin
    gen_valid = 1'b1;
    gen_byte  = 8'h00;
    seg_end   = 1'b0;
    unique case (state_ff)
      ST_TXPRE:
      begin
        gen_byte = is_phr ? `KFPF_PHR_PRE : `KFPF_PRE_AA;
        seg_end  = tx_cnt_ff == `KFPF_PRE_BYTES - 7'h01;
      end
      ST_TXSYNC:
      begin
        if (is_phr)
          gen_byte = tx_cnt_ff[0] ? `KFPF_PHR_SYNC1
                                  : `KFPF_PHR_SYNC0;
        else
          gen_byte = tx_cnt_ff[0] ? `KFPF_SYNC1 : `KFPF_SYNC0;
        seg_end = tx_cnt_ff[0];
      end
      ST_TXHDR:
      begin
        gen_byte = tx_cnt_ff[0] ? tx_hdr[7:0] : tx_hdr[15:8];
        seg_end  = tx_cnt_ff[0];
      end
      ST_TXPAY:
      begin
        if (tx_ack_ff)
        begin
          unique case (tx_cnt_ff[1:0])
            2'h0:    gen_byte = `KFPF_ACK_CH0;
            2'h1:    gen_byte = `KFPF_ACK_CH1;
            default: gen_byte = `KFPF_ACK_CH2;
          endcase
        end
        else
        begin
          gen_valid = HOST_TX_VALID;
          gen_byte  = HOST_TX_DATA;
        end
        seg_end = tx_cnt_ff == pay_n - 7'h01;
      end
      ST_TXCRC:
      begin
        gen_byte = fcs16_ff ? crc16_ff[15:8] : crc32_ff[31:24];
        seg_end  = {4'h0, tx_cnt_ff} == crc_n - 11'h001;
      end
      default:
        gen_valid = 1'b0;
    endcase
  end

  assign take          = gen_valid && (!tx_full_ff || LINK_TX_READY);
  assign HOST_TX_READY = state_ff == ST_TXPAY && !tx_ack_ff &&
                         (!tx_full_ff || LINK_TX_READY);
  assign LINK_TX_VALID = tx_full_ff;
  assign crc_din       = state_ff == ST_RX ? LINK_RX_DATA : gen_byte;
  assign nxt_crc16     = crc16_byte(crc16_ff, crc_din);
  assign nxt_crc32     = crc32_byte(crc32_ff, crc_din);

  // Three stages; only the agreeing later pair is looked at
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      btn_sync_ff <= 3'h0;
      btn_lvl_ff  <= 1'b0;
    end
    else
    begin
      btn_sync_ff <= {btn_sync_ff[1:0], BUTTON};
      if (btn_sync_ff[2] == btn_sync_ff[1])
        btn_lvl_ff <= btn_sync_ff[2];
    end
  end

  // Sequencer; a frame start while sending is ignored
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_ff  <= ST_LISTEN;
      tx_cnt_ff <= 7'h00;
      rx_cnt_ff <= 11'h000;
      rx_len_ff <= `KFPF_LEN_OPEN;
      tx_ack_ff <= 1'b0;
      await_ff  <= 1'b0;
      fcs16_ff  <= 1'b1;
    end
    else if (state_ff == ST_LISTEN || state_ff == ST_RX)
    begin
      if (LINK_RX_START)
      begin
        state_ff  <= ST_RX;
        rx_cnt_ff <= 11'h000;
        fcs16_ff  <= 1'b1;
        unique case (mode)
          MODE_TYPEA:  rx_len_ff <= `KFPF_TYPEA_LEN;
          MODE_TYPEB:  rx_len_ff <= `KFPF_TYPEB_LEN;
          MODE_TWOWAY: rx_len_ff <= await_ff ? `KFPF_ACK_FRAME
                                             : `KFPF_REQ_FRAME;
          MODE_PHR:    rx_len_ff <= `KFPF_LEN_OPEN;
        endcase
      end
      else if (rx_take)
      begin
        rx_cnt_ff <= rx_cnt_ff + 11'h001;
        if (is_phr && rx_cnt_ff == 11'h000)
          fcs16_ff <= rx_rev[`KFPF_HDR_FCS_BIT];
        if (is_phr && rx_cnt_ff == 11'h001)
          rx_len_ff <= `KFPF_HDR_BYTES + rx_hlen;
        if (rx_last)
        begin
          state_ff <= ST_LISTEN;
          if (mode == MODE_TWOWAY || is_phr)
          begin
            await_ff <= 1'b0;
            if (!await_ff && rx_good)
            begin
              state_ff  <= ST_TXPRE;
              tx_ack_ff <= 1'b1;
              tx_cnt_ff <= 7'h00;
              fcs16_ff  <= is_phr ? fcs16_ff : 1'b1;
            end
          end
        end
      end
      else if (state_ff == ST_LISTEN && btn_press &&
               (mode == MODE_TWOWAY || is_phr))
      begin
        state_ff  <= ST_TXPRE;
        tx_ack_ff <= 1'b0;
        tx_cnt_ff <= 7'h00;
        fcs16_ff  <= is_phr ? PHR_FCS16 : 1'b1;
      end
    end
    else if (take)
    begin
      tx_cnt_ff <= seg_end ? 7'h00 : tx_cnt_ff + 7'h01;
      if (seg_end)
      begin
        unique case (state_ff)
          ST_TXPRE:  state_ff <= ST_TXSYNC;
          ST_TXSYNC: state_ff <= is_phr ? ST_TXHDR : ST_TXPAY;
          ST_TXHDR:  state_ff <= ST_TXPAY;
          ST_TXPAY:  state_ff <= ST_TXCRC;
          default:
          begin
            state_ff <= ST_LISTEN;
            await_ff <= !tx_ack_ff;
          end
        endcase
      end
    end
  end

  // CRCs cover only the second field; both engines always run
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      crc16_ff <= `KFPF_CRC16_INIT;
      crc32_ff <= `KFPF_CRC32_INIT;
    end
    // A frame start while sending must not spoil the outgoing CRC
    else if ((state_ff == ST_LISTEN && (btn_press || LINK_RX_START)) ||
             (state_ff == ST_RX && LINK_RX_START) || (rx_take && rx_last))
    begin
      crc16_ff <= `KFPF_CRC16_INIT;
      crc32_ff <= `KFPF_CRC32_INIT;
    end
    else if ((rx_take && rx_cnt_ff >= hdr_off) ||
             (take && state_ff == ST_TXPAY))
    begin
      crc16_ff <= nxt_crc16;
      crc32_ff <= nxt_crc32;
    end
    else if (take && state_ff == ST_TXCRC)
    begin
      crc16_ff <= {crc16_ff[7:0], 8'h00};
      crc32_ff <= {crc32_ff[23:0], 8'h00};
    end
  end

  // Received bytes kept for the copy test and the status field
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rx_b0_ff     <= 8'h00;
      rx_b1_ff     <= 8'h00;
      ack_ok_ff    <= 1'b0;
      BUTTON_STATE <= 5'h00;
      RX_WHITEN    <= 1'b0;
    end
    else if (LINK_RX_START)
      ack_ok_ff <= 1'b1;
    else if (rx_take)
    begin
      if (rx_cnt_ff == 11'h000)
        rx_b0_ff <= LINK_RX_DATA;
      if (rx_cnt_ff == 11'h001)
        rx_b1_ff <= LINK_RX_DATA;
      if (is_phr && rx_cnt_ff == 11'h000)
        RX_WHITEN <= rx_rev[`KFPF_HDR_DW_BIT];
      if (rx_pay && (pay_idx > 11'h002 || LINK_RX_DATA != ack_ch))
        ack_ok_ff <= 1'b0;
      if (mode == MODE_TYPEB && rx_last && rx_good)
        BUTTON_STATE <= rx_b1_ff[`KFPF_BTN_BITS-1:0];
      if (mode == MODE_TYPEB && rx_cnt_ff == `KFPF_TYPEB_STAT)
        rx_b1_ff <= LINK_RX_DATA;
    end
  end

  // Host sees header bytes reversed and payload unchanged
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      HOST_RX_VALID  <= 1'b0;
      HOST_RX_DATA   <= 8'h00;
      HOST_RX_HEADER <= 1'b0;
      HOST_RX_GOOD   <= 1'b0;
      HOST_RX_BAD    <= 1'b0;
    end
    else
    begin
      HOST_RX_VALID  <= rx_take && (rx_pay || rx_cnt_ff < hdr_off) &&
                        mode != MODE_TYPEA && mode != MODE_TYPEB;
      HOST_RX_HEADER <= rx_take && rx_cnt_ff < hdr_off;
      HOST_RX_GOOD   <= rx_take && rx_last && rx_good;
      HOST_RX_BAD    <= rx_take && rx_last && !rx_good;
      if (rx_take)
        HOST_RX_DATA <= rx_cnt_ff < hdr_off ? rx_rev
                                            : LINK_RX_DATA;
    end
  end

  // Output holding register; stalls the generator on back-pressure
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tx_full_ff   <= 1'b0;
      LINK_TX_DATA <= 8'h00;
      LINK_TX_LAST <= 1'b0;
    end
    else if (take)
    begin
      tx_full_ff   <= 1'b1;
      LINK_TX_DATA <= gen_byte;
      LINK_TX_LAST <= state_ff == ST_TXCRC && seg_end;
    end
    else if (LINK_TX_READY)
      tx_full_ff <= 1'b0;
  end

  // Activity LED marks a sent ack and a received good ack
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      ACTIVITY_LED <= 1'b0;
    else if (take && state_ff == ST_TXCRC && seg_end && tx_ack_ff)
      ACTIVITY_LED <= !ACTIVITY_LED;
    else if (rx_take && rx_last && rx_good && await_ff && ack_ok_ff &&
             (mode == MODE_TWOWAY || is_phr))
      ACTIVITY_LED <= !ACTIVITY_LED;
  end

  // Bits 2i+1:2i steer output i, so output three is sent first
  for (genvar g = 0; g < 4; g++)
  begin : g_led
    kfpf_fn_t fn;
    assign fn = kfpf_fn_t'(rx_b0_ff[2*g+1:2*g]);
    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
        led_ff[g] <= 1'b0;
      else if (mode == MODE_TYPEA && rx_take && rx_last && rx_good)
      begin
        unique case (fn)
          FN_LOW:  led_ff[g] <= 1'b0;
          FN_HIGH: led_ff[g] <= 1'b1;
          default: led_ff[g] <= led_ff[g];
        endcase
      end
    end
  end

  assign LED_OUTPUT_THREE = led_ff[3];
  assign LED_OUTPUT_TWO   = led_ff[2];
  assign LED_OUTPUT_ONE   = led_ff[1];
  assign LED_OUTPUT_ZERO  = led_ff[0];

endmodule
`default_nettype wire

/* kfpf_framer_monitor.sv */
// Concurrent checks on the packet framer ports
`timescale 1ns/1ps
`default_nettype none
module kfpf_framer_checker
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [1:0] MODE,
  input wire logic       LINK_RX_VALID,
  input wire logic       LINK_TX_VALID,
  input wire logic       LINK_TX_READY,
  input wire logic [7:0] LINK_TX_DATA,
  input wire logic       LINK_TX_LAST,
  input wire logic       HOST_TX_READY,
  input wire logic       HOST_RX_VALID,
  input wire logic       HOST_RX_HEADER,
  input wire logic       HOST_RX_GOOD,
  input wire logic       HOST_RX_BAD,
  input wire logic [4:0] BUTTON_STATE,
  input wire logic       LED_OUTPUT_THREE,
  input wire logic       LED_OUTPUT_ZERO
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence s_stall;
    LINK_TX_VALID && !LINK_TX_READY;
  endsequence
  sequence s_last_taken;
    LINK_TX_VALID && LINK_TX_READY && LINK_TX_LAST;
  endsequence
  AST_TX_HOLD: assert property (
    s_stall |=> LINK_TX_VALID && $stable(LINK_TX_DATA)
    && $stable(LINK_TX_LAST)) else $error("link byte moved while stalled");
  AST_LAST_END: assert property (
    s_last_taken |=> !LINK_TX_VALID [*2])
    else $error("link kept sending after last byte");
  AST_END_ONE: assert property (
    HOST_RX_GOOD || HOST_RX_BAD |-> $past(LINK_RX_VALID)
    && !(HOST_RX_GOOD && HOST_RX_BAD)) else $error("bad frame verdict");
  AST_RXV_CAUSE: assert property (
    HOST_RX_VALID |-> $past(LINK_RX_VALID) && MODE[1])
    else $error("host byte without link byte");
  AST_HDR_MODE3: assert property (
    HOST_RX_HEADER |-> HOST_RX_VALID && MODE == 2'h3)
    else $error("header byte outside header mode");
  AST_LED_HOLD: assert property (
    $changed({LED_OUTPUT_THREE, LED_OUTPUT_ZERO})
    |-> HOST_RX_GOOD && MODE == 2'h0) else $error("led moved without frame");
  AST_BTN_HOLD: assert property (
    $changed(BUTTON_STATE) |-> HOST_RX_GOOD && MODE == 2'h1)
    else $error("button state moved without frame");
  AST_RX_ONLY: assert property (
    LINK_TX_VALID || HOST_TX_READY |-> MODE[1])
    else $error("transmit in receive-only mode");
endmodule
bind kfpf_framer kfpf_framer_checker i_chk
(
  .CLK(CLK), .RST(RST), .MODE(MODE), .LINK_RX_VALID(LINK_RX_VALID),
  .LINK_TX_VALID(LINK_TX_VALID), .LINK_TX_READY(LINK_TX_READY),
  .LINK_TX_DATA(LINK_TX_DATA), .LINK_TX_LAST(LINK_TX_LAST),
  .HOST_TX_READY(HOST_TX_READY), .HOST_RX_VALID(HOST_RX_VALID),
  .HOST_RX_HEADER(HOST_RX_HEADER), .HOST_RX_GOOD(HOST_RX_GOOD),
  .HOST_RX_BAD(HOST_RX_BAD), .BUTTON_STATE(BUTTON_STATE),
  .LED_OUTPUT_THREE(LED_OUTPUT_THREE), .LED_OUTPUT_ZERO(LED_OUTPUT_ZERO)
);
`default_nettype wire

/* kfpf_remote_node.sv */
// Remote radio node model feeding and draining the link side
`timescale 1ns/1ps
`default_nettype none
module kfpf_remote_node
#(
  parameter logic [31:0] CHIP_ID = 32'h1234ABCD // Arbitrary value
)
(
  input  wire logic       clk,
  output logic            rx_start,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last
);
  logic [7:0]  got[$];
  logic        lastq[$];
  logic        slow = 1'b0;
  logic [15:0] cnt = 16'h0001;
  initial
  begin
    rx_start = 1'b0;
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
  end
  // Slow mode drops ready every other cycle to exercise the stall path
  always @(negedge clk)
    tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clk)
    if (tx_valid && tx_ready)
    begin
      got.push_back(tx_data);
      lastq.push_back(tx_last);
    end
  // MSB first, no final xor; upper half is zeroed for the 16-bit case
  function automatic logic [31:0] crc(input logic [7:0] b[$], input bit w);
    logic [31:0] c;
    logic        t;
    c = 32'hFFFFFFFF;
    foreach (b[i])
      for (int k = 7; k >= 0; k--)
      begin
        t = (w ? c[31] : c[15]) ^ b[i][k];
        c = {c[30:0], 1'b0} ^ (t ? (w ? 32'h04C11DB7 : 32'h00008005) : 32'h0);
      end
    return w ? c : {16'h0000, c[15:0]};
  endfunction
  task automatic send(input logic [7:0] b[$]);
    @(negedge clk);
    rx_start = 1'b1;
    @(negedge clk);
    rx_start = 1'b0;
    foreach (b[i])
    begin
      rx_valid = 1'b1;
      rx_data  = b[i];
      @(negedge clk);
    end
    // Released line shows the inverse so a stale byte never matches
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask
  task automatic send_typeb(input logic [7:0] st, input logic bad);
    logic [7:0]  q[$];
    logic [31:0] c;
    q = '{CHIP_ID[31:24], CHIP_ID[23:16], CHIP_ID[15:8], CHIP_ID[7:0],
      st, cnt[15:8], cnt[7:0]};
    c = crc(q, 1'b0);
    q.push_back(c[15:8]);
    q.push_back(c[7:0] ^ {7'h00, bad});
    cnt++;
    send(q);
  endtask
endmodule
`default_nettype wire

/* kfpf_framer_test.sv */
// Self-checking bench for the packet framer
`timescale 1ns/1ps
`default_nettype none
module kfpf_framer_test;
  logic       clk, rst, fcs16, whiten, button, rx_start, rx_valid;
  logic       tx_valid, tx_ready, tx_last, h_valid, h_ready, hdr;
  logic       good, bad, rx_whiten, act, h_rx_valid;
  logic [1:0] mode;
  logic [3:0] led;
  logic [4:0] btn_state;
  logic [7:0] rx_data, tx_data, h_data, h_rx_data;
  logic [7:0] hq[$];
  int         n_errors = 0;
  int         n_checks = 0;
  int         n_hdr = 0;
  kfpf_framer i_dut
  (
    .CLK(clk), .RST(rst), .MODE(mode), .PHR_FCS16(fcs16),
    .PHR_WHITEN(whiten), .BUTTON(button), .LINK_RX_START(rx_start),
    .LINK_RX_VALID(rx_valid), .LINK_RX_DATA(rx_data),
    .LINK_TX_VALID(tx_valid), .LINK_TX_READY(tx_ready),
    .LINK_TX_DATA(tx_data), .LINK_TX_LAST(tx_last),
    .HOST_TX_VALID(h_valid), .HOST_TX_READY(h_ready),
    .HOST_TX_DATA(h_data), .HOST_RX_VALID(h_rx_valid),
    .HOST_RX_DATA(h_rx_data),
    .HOST_RX_HEADER(hdr), .HOST_RX_GOOD(good), .HOST_RX_BAD(bad),
    .RX_WHITEN(rx_whiten), .LED_OUTPUT_THREE(led[3]),
    .LED_OUTPUT_TWO(led[2]), .LED_OUTPUT_ONE(led[1]),
    .LED_OUTPUT_ZERO(led[0]), .BUTTON_STATE(btn_state), .ACTIVITY_LED(act)
  );
  kfpf_remote_node i_node
  (
    .clk(clk), .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last)
  );
  always @(posedge clk)
  begin
    if (hdr)
      n_hdr++;
    if (h_rx_valid)
      hq.push_back(h_rx_data);
  end
  task automatic chk(input string what, input logic [31:0] e, got);
    n_checks++;
    if (got !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask
  // Verdict pulse stands in the cycle right after the last byte
  task automatic fin(input logic g);
    chk("good", 32'(g), 32'(good));
    chk("bad", 32'(!g), 32'(bad));
  endtask
  task automatic expect_tx(input logic [7:0] e[$]);
    for (int i = 0; i < 600 && i_node.got.size() < e.size(); i++)
      @(negedge clk);
    chk("tx count", 32'(e.size()), 32'(i_node.got.size()));
    foreach (e[i])
    begin
      chk("tx byte", e[i], i_node.got[i]);
      chk("tx last", 32'(i == e.size() - 1), 32'(i_node.lastq[i]));
    end
    i_node.got.delete();
    i_node.lastq.delete();
  endtask
  task automatic t_typea();
    mode = 2'h0;
    i_node.send('{8'hAA, 8'h55, 8'hAA});
    fin(1'b1);
    chk("leds", 32'hF, 32'(led));
    i_node.send('{8'h63, 8'h9C, 8'h63});
    fin(1'b1);
    chk("leds", 32'h7, 32'(led));
    i_node.send('{8'h55, 8'hAB, 8'h55});
    fin(1'b0);
    i_node.send('{8'h55, 8'hAA, 8'h56});
    fin(1'b0);
    chk("leds", 32'h7, 32'(led));
    $display("test typea done");
  endtask
  task automatic t_typeb();
    mode = 2'h1;
    i_node.send_typeb(8'hF5, 1'b0);
    fin(1'b1);
    chk("button", 32'h15, 32'(btn_state));
    i_node.send_typeb(8'h0A, 1'b1);
    fin(1'b0);
    chk("button", 32'h15, 32'(btn_state));
    $display("test typeb done");
  endtask
  task automatic t_twoway();
    logic [7:0]  q[$], bq[$];
    logic [31:0] c;
    logic        a0;
    mode = 2'h2;
    for (int i = 0; i < 64; i++)
      q.push_back(8'h80 + 8'(i));
    c = i_node.crc(q, 1'b0);
    q.push_back(c[15:8]);
    q.push_back(c[7:0]);
    bq = q;
    bq[65] ^= 8'h01;
    i_node.send(bq);
    fin(1'b0);
    i_node.slow = 1'b1;
    a0 = act;
    i_node.send(q);
    fin(1'b1);
    c = i_node.crc('{8'h41, 8'h43, 8'h4B}, 1'b0);
    expect_tx('{8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'h2D, 8'hD4, 8'h41, 8'h43,
      8'h4B, c[15:8], c[7:0]});
    repeat (2) @(negedge clk);
    chk("activity", 32'(!a0), 32'(act));
    i_node.slow = 1'b0;
    $display("test twoway done");
  endtask
  task automatic phr_req(input logic f16);
    logic [7:0]  e[$], q[$];
    logic [31:0] c;
    fcs16 = f16;
    for (int i = 0; i < 64; i++)
      q.push_back(8'(i));
    c = i_node.crc(q, !f16);
    // Header word: flag and reserved zero, FCS type, DW set, length
    e = '{8'h55, 8'h55, 8'h55, 8'h55, 8'h90, 8'h4E, {3'h0, f16, 4'h8},
      f16 ? 8'h42 : 8'h44};
    e = {e, q};
    if (!f16)
      e = {e, c[31:24], c[23:16]};
    e = {e, c[15:8], c[7:0]};
    fork
      begin
        button = 1'b1;
        repeat (8) @(negedge clk);
        button = 1'b0;
      end
      foreach (q[i])
      begin
        h_valid = 1'b1;
        h_data = q[i];
        @(posedge clk);
        while (!h_ready)
          @(posedge clk);
        @(negedge clk);
      end
    join
    h_valid = 1'b0;
    expect_tx(e);
  endtask
  task automatic t_phr();
    logic [7:0]  q[$];
    logic [31:0] c;
    logic        a0;
    mode = 2'h3;
    whiten = 1'b1;
    phr_req(1'b1);
    q = '{8'h41, 8'h43, 8'h4B};
    c = i_node.crc(q, 1'b1);
    a0 = act;
    n_hdr = 0;
    hq.delete();
    i_node.send({8'h10, 8'hE0, q, c[31:24], c[23:16], c[15:8], c[7:0]});
    fin(1'b1);
    chk("whiten", 32'h1, 32'(rx_whiten));
    chk("headers", 32'h2, 32'(n_hdr));
    chk("activity", 32'(!a0), 32'(act));
    chk("host rx n", 32'h5, 32'(hq.size()));
    chk("host rx", 32'h08074143, {hq[0], hq[1], hq[2], hq[3]});
    chk("host rx end", 32'h4B, 32'(hq[4]));
    phr_req(1'b0);
    $display("test phr done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    {rst, fcs16, whiten, button, h_valid, h_data, mode} = {1'b1, 14'h0};
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_typea();
    t_typeb();
    t_twoway();
    t_phr();
    report_and_stop();
  end
endmodule
`default_nettype wire
